// >>> rtl/pdx_defs.svh
// Constants of the message exchange and role policy block
`ifndef PDX_DEFS_SVH
`define PDX_DEFS_SVH

// ****************************************
// Message fields
// ****************************************
`define PDX_DATA_W      10
`define PDX_ID_W        3
`define PDX_SOP_W       2
`define PDX_SOP_NUM     3
`define PDX_CRC_W       8
`define PDX_CRC_POLY    8'h07
`define PDX_CRC_INIT    8'hFF
`define PDX_ID_RST      3'h0

// ****************************************
// Timing
// ****************************************
`define PDX_CLK_NS      10
`define PDX_ACK_WAIT_NS 1000
`define PDX_ACK_CYCLES  ((`PDX_ACK_WAIT_NS + `PDX_CLK_NS - 1) / `PDX_CLK_NS)
`define PDX_RETRY_LIMIT 3
`define PDX_TMR_W       12
`define PDX_RTY_W       3

`endif

// >>> rtl/pdx_pkg.sv
// Types and shared functions of the message exchange block
package pdx_pkg;
`include "pdx_defs.svh"

    // ****************************************
    // Message layout
    // ****************************************
    typedef struct packed {
        logic [`PDX_SOP_W-1:0]  sop;
        logic                   isAck;
        logic [`PDX_ID_W-1:0]   msgId;
        logic [`PDX_DATA_W-1:0] data;
    } pdx_body_t;

    typedef struct packed {
        logic [`PDX_CRC_W-1:0] crc;
        pdx_body_t             body;
    } pdx_word_t;

    typedef logic [`PDX_SOP_NUM-1:0][`PDX_ID_W-1:0] pdx_ids_t;

    // ****************************************
    // States
    // ****************************************
    typedef enum logic {
        PDX_TX_IDLE = 1'b0,
        PDX_TX_WAIT = 1'b1
    } pdx_tx_e_t;

    typedef enum logic [1:0] {
        PDX_DB_IDLE   = 2'b00,
        PDX_DB_SINK   = 2'b01,
        PDX_DB_PROBE  = 2'b10,
        PDX_DB_SOURCE = 2'b11
    } pdx_db_e_t;

    // ****************************************
    // Shared functions
    // ****************************************
    // Bitwise CRC over the message body
    function automatic logic [`PDX_CRC_W-1:0] pdx_crc(input pdx_body_t b);
        logic [`PDX_CRC_W-1:0] c;
        logic [15:0]           d;
        logic                  fb;
        c = `PDX_CRC_INIT;
        d = b;
        for (int i = 15; i >= 0; i--)
        begin
            fb = c[7] ^ d[i];
            c  = {c[6:0], 1'b0} ^ (fb ? `PDX_CRC_POLY : 8'h00);
        end
        return c;
    endfunction

    function automatic pdx_word_t pdx_frame(input pdx_body_t b);
        return {pdx_crc(b), b};
    endfunction

    function automatic logic pdx_crc_ok(input pdx_word_t w);
        return w.crc == pdx_crc(w.body);
    endfunction

    // Swap decision; equal supplies are denied to stop swap ping-pong
    function automatic logic pdx_swap_ok(input logic localExt,
                                         input logic peerExt,
                                         input logic peerCanMeet);
        return !localExt && peerExt && peerCanMeet;
    endfunction

    // ****************************************
    // Module state
    // ****************************************
    typedef struct packed {
        pdx_tx_e_t             txSt;
        logic [1:0]            sop;
        pdx_word_t             msg;
        logic                  msgValid;
        pdx_ids_t              txId;
        logic [`PDX_TMR_W-1:0] tmr;
        logic [`PDX_RTY_W-1:0] rty;
        logic                  busy;
        logic                  done;
        logic [1:0]            doneSop;
        logic                  fail;
        logic                  swapAccept;
        logic                  swapDeny;
        logic [4:0]            sync1;
        logic [4:0]            sync2;
        pdx_db_e_t             dbSt;
        logic                  roleSink;
        logic                  roleSource;
        logic                  driveSafeDb;
        logic                  driveSafe5v;
        logic                  commFromBus;
        logic                  attachPrev;
        logic                  attachChange;
        logic [9:0]            capsPrev;
        logic                  capsChange;
        logic                  supplyPrev;
        logic                  transDone;
        logic                  reqValid;
        logic [9:0]            reqCurrent;
        logic                  morePower;
    } pdx_dev_st_t;

    typedef struct packed {
        logic [`PDX_SOP_NUM-1:0] seen;
        pdx_ids_t                lastId;
        logic                    ackValid;
        pdx_word_t               ackWord;
        logic                    rxValid;
        logic [1:0]              rxSop;
        logic [9:0]              rxData;
        logic                    rxRetry;
        logic                    rxCrcErr;
        logic                    swapAccept;
        logic                    swapDeny;
    } pdx_far_st_t;

endpackage

// >>> rtl/pdx_link_if.sv
// Link between the device end and the far end
interface pdx_link_if
    import pdx_pkg::*;
();
    // Message from device end, acknowledge from far end
    logic      msgValid;
    pdx_word_t msgWord;
    logic      ackValid;
    pdx_word_t ackWord;

    modport dev (output msgValid, output msgWord, input ackValid, input ackWord);
    modport far (input msgValid, input msgWord, output ackValid, output ackWord);
endinterface

// >>> rtl/pdx_far_end.sv
// Far end: message receiver with repeat filter and swap decision
`include "pdx_defs.svh"
module pdx_far_end
    import pdx_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    // Link
    pdx_link_if.far          link,
    // Receive controls
    input  wire logic        rxIgnore,
    // Delivery to policy engine
    output logic             rxValid,
    output logic [1:0]       rxSop,
    output logic [9:0]       rxData,
    output logic             rxRetry,
    output logic             rxCrcErr,
    // Role swap request from the device end
    input  wire logic        swapReq,
    input  wire logic        localExt,
    input  wire logic        peerExt,
    input  wire logic        peerCanMeet,
    output logic             swapAccept,
    output logic             swapDeny
);

    // ****************************************
    // State
    // ****************************************
    pdx_far_st_t st;
    pdx_far_st_t next_st;
    pdx_body_t   inBody;
    logic        inGood;
    logic        inSopOk;

    assign inBody  = link.msgWord.body;
    assign inSopOk = inBody.sop < 2'(`PDX_SOP_NUM);
    // Noise model drops the frame before any check
    assign inGood  = link.msgValid && !rxIgnore && pdx_crc_ok(link.msgWord);

    // Next state
    always_comb
    begin
        next_st            = st;
        next_st.ackValid   = 1'b0;
        next_st.rxValid    = 1'b0;
        next_st.rxRetry    = 1'b0;
        next_st.rxCrcErr   = 1'b0;
        next_st.swapAccept = 1'b0;
        next_st.swapDeny   = 1'b0;
        if (link.msgValid && !rxIgnore && !pdx_crc_ok(link.msgWord))
        begin
            next_st.rxCrcErr = 1'b1;
        end
        if (inGood && !inBody.isAck && inSopOk)
        begin
            // Retries are still answered, so the sender stops resending
            next_st.ackValid = 1'b1;
            next_st.ackWord  = pdx_frame({inBody.sop, 1'b1, inBody.msgId,
                                          `PDX_DATA_W'(0)});
            if (!st.seen[inBody.sop] || st.lastId[inBody.sop] != inBody.msgId)
            begin
                next_st.seen[inBody.sop]   = 1'b1;
                next_st.lastId[inBody.sop] = inBody.msgId;
                next_st.rxValid            = 1'b1;
                next_st.rxSop              = inBody.sop;
                next_st.rxData             = inBody.data;
            end
            else
            begin
                next_st.rxRetry = 1'b1;
            end
        end
        // Swap decision
        if (swapReq)
        begin
            next_st.swapAccept = pdx_swap_ok(localExt, peerExt, peerCanMeet);
            next_st.swapDeny   = !pdx_swap_ok(localExt, peerExt, peerCanMeet);
        end
    end

    // Register
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            st <= '0;
        else
            st <= next_st;
    end

    // Outputs
    assign link.ackValid = st.ackValid;
    assign link.ackWord  = st.ackWord;
    assign rxValid       = st.rxValid;
    assign rxSop         = st.rxSop;
    assign rxData        = st.rxData;
    assign rxRetry       = st.rxRetry;
    assign rxCrcErr      = st.rxCrcErr;
    assign swapAccept    = st.swapAccept;
    assign swapDeny      = st.swapDeny;

endmodule

// >>> rtl/pdx_dev_end.sv
// Device end: sender, role swap, dead battery takeover, policy manager
`include "pdx_defs.svh"
module pdx_dev_end
    import pdx_pkg::*;
#(
    parameter int ACK_CYCLES  = `PDX_ACK_CYCLES,
    parameter int RETRY_LIMIT = `PDX_RETRY_LIMIT
)
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    // Link
    pdx_link_if.dev          link,
    // Policy engine send port
    input  wire logic        sendReq,
    input  wire logic [1:0]  sendSop,
    input  wire logic [9:0]  sendData,
    output logic             sendBusy,
    output logic             sendDone,
    output logic [1:0]       doneSop,
    output logic             sendFail,
    // Role swap request from the partner
    input  wire logic        swapReq,
    input  wire logic        localExt,
    input  wire logic        peerExt,
    input  wire logic        peerCanMeet,
    output logic             swapAccept,
    output logic             swapDeny,
    // Dead battery pins
    input  wire logic        srcDefault,
    input  wire logic        vbusPresent,
    input  wire logic        batteryDead,
    input  wire logic        peerDbCapable,
    input  wire logic        bitStreamSeen,
    output logic             roleSink,
    output logic             roleSource,
    output logic             driveSafeDb,
    output logic             driveSafe5v,
    output logic             commFromBus,
    // Source side policy manager
    input  wire logic        attached,
    input  wire logic [9:0]  srcCaps,
    input  wire logic        supplyReady,
    output logic             attachChange,
    output logic             capsChange,
    output logic             transDone,
    // Sink side policy manager
    input  wire logic        offerValid,
    input  wire logic [9:0]  offerCurrent,
    input  wire logic [9:0]  needCurrent,
    output logic             reqValid,
    output logic [9:0]       reqCurrent,
    output logic             morePower
);

    // ****************************************
    // Constants and state
    // ****************************************
    localparam logic [`PDX_TMR_W-1:0] ACK_T = `PDX_TMR_W'(ACK_CYCLES - 1);
    localparam logic [`PDX_RTY_W-1:0] RTY_T = `PDX_RTY_W'(RETRY_LIMIT);

    pdx_dev_st_t st;
    pdx_dev_st_t next_st;
    pdx_body_t   ackBody;
    logic        ackGood;
    logic        pinSrcDef;
    logic        pinVbus;
    logic        pinBattDead;
    logic        pinPeerDb;
    logic        pinBitStream;

    // Synchronised pin levels, second stage only
    assign {pinSrcDef, pinVbus, pinBattDead, pinPeerDb, pinBitStream} = st.sync2;

    // Acknowledge must match the pending frame's start type and tag
    assign ackBody = link.ackWord.body;
    assign ackGood = link.ackValid && pdx_crc_ok(link.ackWord) && ackBody.isAck
                     && ackBody.sop == st.sop
                     && ackBody.msgId == st.txId[st.sop];

    // Next state
    always_comb
    begin
        next_st              = st;
        next_st.msgValid     = 1'b0;
        next_st.done         = 1'b0;
        next_st.fail         = 1'b0;
        next_st.swapAccept   = 1'b0;
        next_st.swapDeny     = 1'b0;
        next_st.attachChange = 1'b0;
        next_st.capsChange   = 1'b0;
        next_st.transDone    = 1'b0;
        next_st.reqValid     = 1'b0;

        // ****************************************
        // Message sender
        // ****************************************
        // Each start type keeps its own sequence counter
        unique case (st.txSt)
            PDX_TX_IDLE:
            begin
                // Requests for an unknown start type are dropped
                if (sendReq && sendSop < 2'(`PDX_SOP_NUM))
                begin
                    next_st.sop      = sendSop;
                    next_st.msg      = pdx_frame({sendSop, 1'b0, st.txId[sendSop],
                                                  sendData});
                    next_st.msgValid = 1'b1;
                    next_st.tmr      = ACK_T;
                    next_st.rty      = '0;
                    next_st.txSt     = PDX_TX_WAIT;
                end
            end
            PDX_TX_WAIT:
            begin
                if (ackGood)
                begin
                    next_st.txId[st.sop] = st.txId[st.sop] + `PDX_ID_W'(1);
                    next_st.done         = 1'b1;
                    next_st.doneSop      = st.sop;
                    next_st.txSt         = PDX_TX_IDLE;
                end
                else if (st.tmr != '0)
                begin
                    next_st.tmr = st.tmr - `PDX_TMR_W'(1);
                end
                else if (st.rty < RTY_T)
                begin
                    // Same frame, same tag, so the receiver can spot it
                    next_st.rty      = st.rty + `PDX_RTY_W'(1);
                    next_st.msgValid = 1'b1;
                    next_st.tmr      = ACK_T;
                end
                else
                begin
                    next_st.fail = 1'b1;
                    next_st.txSt = PDX_TX_IDLE;
                end
            end
        endcase
        next_st.busy = next_st.txSt == PDX_TX_WAIT;

        // ****************************************
        // Power role swap decision
        // ****************************************
        if (swapReq)
        begin
            next_st.swapAccept = pdx_swap_ok(localExt, peerExt, peerCanMeet);
            next_st.swapDeny   = !pdx_swap_ok(localExt, peerExt, peerCanMeet);
        end

        // ****************************************
        // Dead battery takeover
        // ****************************************
        next_st.sync1 = {srcDefault, vbusPresent, batteryDead, peerDbCapable,
                         bitStreamSeen};
        next_st.sync2 = st.sync1;
        unique case (st.dbSt)
            PDX_DB_IDLE:
            begin
                if (pinSrcDef && pinVbus && pinBattDead)
                    next_st.dbSt = PDX_DB_SINK;
                else if (!pinSrcDef && pinPeerDb && !pinVbus)
                    next_st.dbSt = PDX_DB_PROBE;
            end
            PDX_DB_SINK:
            begin
                // Bus gone means the back power is gone too
                if (!pinVbus)
                    next_st.dbSt = PDX_DB_IDLE;
            end
            PDX_DB_PROBE:
            begin
                if (pinBitStream)
                    next_st.dbSt = PDX_DB_SOURCE;
                else if (!pinPeerDb)
                    next_st.dbSt = PDX_DB_IDLE;
            end
            PDX_DB_SOURCE:
            begin
                if (!pinPeerDb)
                    next_st.dbSt = PDX_DB_IDLE;
            end
        endcase
        // Role outputs follow the state, no swap message involved
        next_st.roleSink    = next_st.dbSt == PDX_DB_SINK;
        next_st.commFromBus = next_st.dbSt == PDX_DB_SINK;
        next_st.driveSafeDb = next_st.dbSt == PDX_DB_PROBE;
        next_st.roleSource  = next_st.dbSt == PDX_DB_SOURCE;
        next_st.driveSafe5v = next_st.dbSt == PDX_DB_SOURCE;

        // ****************************************
        // Policy manager, this port's own interface
        // ****************************************
        next_st.attachPrev   = attached;
        next_st.attachChange = attached != st.attachPrev;
        next_st.capsPrev     = srcCaps;
        next_st.capsChange   = srcCaps != st.capsPrev;
        next_st.supplyPrev   = supplyReady;
        next_st.transDone    = supplyReady && !st.supplyPrev;
        if (offerValid)
        begin
            // Ask for what is needed, capped at what is offered
            next_st.reqValid   = 1'b1;
            next_st.reqCurrent = (needCurrent > offerCurrent) ? offerCurrent
                                                              : needCurrent;
            next_st.morePower  = needCurrent > offerCurrent;
        end
    end

    // Register
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            st <= '0;
        else
            st <= next_st;
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign link.msgValid = st.msgValid;
    assign link.msgWord  = st.msg;
    assign sendBusy      = st.busy;
    assign sendDone      = st.done;
    assign doneSop       = st.doneSop;
    assign sendFail      = st.fail;
    assign swapAccept    = st.swapAccept;
    assign swapDeny      = st.swapDeny;
    assign roleSink      = st.roleSink;
    assign roleSource    = st.roleSource;
    assign driveSafeDb   = st.driveSafeDb;
    assign driveSafe5v   = st.driveSafe5v;
    assign commFromBus   = st.commFromBus;
    assign attachChange  = st.attachChange;
    assign capsChange    = st.capsChange;
    assign transDone     = st.transDone;
    assign reqValid      = st.reqValid;
    assign reqCurrent    = st.reqCurrent;
    assign morePower     = st.morePower;

endmodule

// >>> sim/pdx_link_assertions.sv
// Reference CRC and link checker for the message exchange pair
// ****************************************
// Reference CRC
// ****************************************
package pdx_chk_pkg;
    import pdx_pkg::*;
    // Written apart from the design so a shared slip cannot hide
    function automatic logic [7:0] pdx_ref_crc(input pdx_body_t b);
        logic [7:0]  c;
        logic [15:0] d;
        c = 8'hFF;
        d = b;
        for (int i = 15; i >= 0; i--)
        begin
            c = {c[6:0], 1'h0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        end
        return c;
    endfunction
endpackage

// ****************************************
// Checker
// ****************************************
module pdx_link_checker
    import pdx_pkg::*;
    import pdx_chk_pkg::*;
#(
    parameter int ACK_CYCLES = 4
)
(
    // Clock and reset
    input wire logic      core_clk,
    input wire logic      reset_n,
    // Link signals
    input wire logic      msgValid,
    input wire pdx_word_t msgWord,
    input wire logic      ackValid,
    input wire pdx_word_t ackWord
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    // Every frame on the wire is protected and is a plain message
    a_msg_crc_good: assert property (msgValid |-> msgWord.crc == pdx_ref_crc(msgWord.body))
        else $error("frame CRC wrong");
    a_msg_kind_ok: assert property (msgValid |-> !msgWord.body.isAck && msgWord.body.sop != 2'h3)
        else $error("frame kind wrong");
    // Acknowledge only answers a frame of the cycle before
    a_ack_after_msg: assert property (ackValid |-> $past(msgValid))
        else $error("acknowledge without frame");
    a_ack_crc_good: assert property (ackValid |-> ackWord.crc == pdx_ref_crc(ackWord.body))
        else $error("acknowledge CRC wrong");
    a_ack_echo_ok: assert property (ackValid |-> ackWord.body.isAck && ackWord.body.data == 10'h000
        && ackWord.body.sop == $past(msgWord.body.sop)
        && ackWord.body.msgId == $past(msgWord.body.msgId))
        else $error("acknowledge fields wrong");
    // One outstanding frame: never two frames closer than three cycles
    a_msg_spacing: assert property (msgValid |=> !msgValid [*2])
        else $error("frames too close");
    // A resend after a missing acknowledge repeats the frame unchanged
    a_resend_same: assert property (msgValid && $past(msgValid, ACK_CYCLES)
        && !$past(ackValid, ACK_CYCLES - 1) |-> msgWord == $past(msgWord, ACK_CYCLES))
        else $error("resend differs");
    // Tag advances by one after a good acknowledge
    a_tag_step: assert property (msgValid && $past(ackValid, 2) && $past(msgValid, 3)
        && msgWord.body.sop == $past(msgWord.body.sop, 3)
        |-> msgWord.body.msgId == $past(msgWord.body.msgId, 3) + 3'h1)
        else $error("tag not advanced");
endmodule

// >>> sim/pd_message_exchange_role_policy_tb.sv
// Self-checking bench joining the device end and the far end
module pd_message_exchange_role_policy_tb
    import pdx_pkg::*;
    import pdx_chk_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // Short counts keep the timeout runs brief
    localparam int AC = 4;
    localparam int RL = 1;
    logic core_clk, reset_n, sendReq, rxIgnore, swapReq, localExt, peerExt, peerCanMeet;
    logic srcDefault, vbusPresent, batteryDead, peerDbCapable, bitStreamSeen;
    logic attached, supplyReady, offerValid, sendBusy, sendDone, sendFail, dSwA, dSwD;
    logic roleSink, roleSource, driveSafeDb, driveSafe5v, commFromBus, attachChange;
    logic capsChange, transDone, reqValid, morePower, rxValid, rxRetry, rxCrcErr;
    logic fSwA, fSwD, f2Valid, f2Retry, f2Err;
    logic [1:0] sendSop, doneSop, rxSop;
    logic [9:0] sendData, srcCaps, offerCurrent, needCurrent, reqCurrent, rxData, pick;
    logic [4:0] dbIn [5] = '{5'h1C, 5'h14, 5'h02, 5'h03, 5'h01};
    logic [4:0] dbOut [5] = '{5'h11, 5'h00, 5'h04, 5'h0A, 5'h00};
    int bad_count = 0;
    int cmp_count = 0;
    pdx_link_if link();
    pdx_link_if link2();
    pdx_dev_end #(.ACK_CYCLES(AC), .RETRY_LIMIT(RL)) pdx_dev_end_inst (.core_clk, .reset_n,
        .link, .sendReq, .sendSop, .sendData, .sendBusy, .sendDone, .doneSop, .sendFail,
        .swapReq, .localExt, .peerExt, .peerCanMeet, .swapAccept(dSwA), .swapDeny(dSwD),
        .srcDefault, .vbusPresent, .batteryDead, .peerDbCapable, .bitStreamSeen, .roleSink,
        .roleSource, .driveSafeDb, .driveSafe5v, .commFromBus, .attached, .srcCaps,
        .supplyReady, .attachChange, .capsChange, .transDone, .offerValid, .offerCurrent,
        .needCurrent, .reqValid, .reqCurrent, .morePower);
    pdx_far_end pdx_far_end_inst (.core_clk, .reset_n, .link, .rxIgnore, .rxValid, .rxSop,
        .rxData, .rxRetry, .rxCrcErr, .swapReq, .localExt, .peerExt, .peerCanMeet,
        .swapAccept(fSwA), .swapDeny(fSwD));
    // Second far end faces the bench driver, which can break the link rules
    pdx_far_end pdx_far_end_inst2 (.core_clk, .reset_n, .link(link2), .rxIgnore(1'h0),
        .rxValid(f2Valid), .rxSop(), .rxData(), .rxRetry(f2Retry), .rxCrcErr(f2Err), .swapReq,
        .localExt, .peerExt, .peerCanMeet, .swapAccept(), .swapDeny());
    pdx_link_checker #(.ACK_CYCLES(AC)) pdx_link_checker_inst (.core_clk, .reset_n,
        .msgValid(link.msgValid), .msgWord(link.msgWord),
        .ackValid(link.ackValid), .ackWord(link.ackWord));

    always #5 core_clk = ~core_clk;

    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        if (bad_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Settle just after an edge so registered outputs have landed
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // One send; a dropped request is watched for twelve cycles
    task automatic send(input logic [1:0] sop, input logic [9:0] dat, input logic ign);
        int n;
        int msgs;
        int rx;
        logic ok;
        ok = sop != 2'h3 && !ign;
        msgs = 0;
        rx = 0;
        @(posedge core_clk);
        sendReq <= 1'h1;
        sendSop <= sop;
        sendData <= dat;
        rxIgnore <= ign;
        for (n = 1; n <= 40; n++)
        begin
            step(1);
            sendReq <= 1'h0;
            msgs += int'(link.msgValid === 1'h1);
            if (n == 1)
                check(sendBusy, sop != 2'h3);
            if ({rxValid, rxRetry, rxCrcErr} !== 3'h0)
            begin
                rx++;
                check({rxRetry, rxCrcErr, rxSop, rxData}, {2'h0, sop, dat});
            end
            if (sendDone === 1'h1 || sendFail === 1'h1 || (sop == 2'h3 && n == 12))
                break;
        end
        if (n > 40)
            bad_count++;
        check(24'(n), sop == 2'h3 ? 24'd12 : ign ? 24'((RL + 1) * AC + 1) : 24'd3);
        check(24'(msgs), !ok && sop != 2'h3 ? 24'(RL + 1) : 24'(ok));
        check(24'(rx), 24'(ok));
        check({sendDone, sendFail, sendBusy}, {ok, ign && sop != 2'h3, 1'h0});
        if (ok)
            check(doneSop, sop);
    endtask

    // Bench-built frame into the second far end
    task automatic inject(input pdx_body_t b, input logic bad, input logic [3:0] exp);
        @(posedge core_clk);
        link2.msgValid <= 1'h1;
        link2.msgWord <= {pdx_ref_crc(b) ^ {7'h00, bad}, b};
        step(1);
        link2.msgWord <= ~link2.msgWord;
        link2.msgValid <= 1'h0;
        check({link2.ackValid, f2Valid, f2Retry, f2Err}, exp);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        {core_clk, reset_n, sendReq, rxIgnore, swapReq, localExt, peerExt} = '0;
        {peerCanMeet, srcDefault, vbusPresent, batteryDead, peerDbCapable} = '0;
        {bitStreamSeen, attached, supplyReady, offerValid, sendSop, sendData} = '0;
        {srcCaps, offerCurrent, needCurrent, link2.msgValid, link2.msgWord} = '0;
        void'($urandom(11));
        repeat (12) @(posedge core_clk);
        reset_n <= 1'h1;
        for (int i = 0; i < 12; i++)
            send(2'($urandom_range(0, 2)), 10'($urandom), 1'h0);
        send(2'h3, 10'h155, 1'h0);
        send(2'h0, 10'h3FF, 1'h1);
        send(2'h0, 10'h000, 1'h0);
        // Request held high: each new frame is taken in the done cycle
        @(posedge core_clk);
        sendReq <= 1'h1;
        sendSop <= 2'h1;
        repeat (12) @(posedge core_clk);
        sendReq <= 1'h0;
        step(8);
        inject('{2'h1, 1'h0, 3'h5, 10'h2A5}, 1'h0, 4'hC);
        inject('{2'h1, 1'h0, 3'h5, 10'h2A5}, 1'h0, 4'hA);
        inject('{2'h1, 1'h0, 3'h6, 10'h11B}, 1'h1, 4'h1);
        inject('{2'h1, 1'h0, 3'h6, 10'h11B}, 1'h0, 4'hC);
        inject('{2'h2, 1'h0, 3'h6, 10'h0F0}, 1'h0, 4'hC);
        inject('{2'h1, 1'h1, 3'h2, 10'h000}, 1'h0, 4'h0);
        inject('{2'h3, 1'h0, 3'h2, 10'h000}, 1'h0, 4'h0);
        // Swap requests back to back over every supply combination
        for (int i = 0; i < 8; i++)
        begin
            @(posedge core_clk);
            swapReq <= 1'h1;
            {localExt, peerExt, peerCanMeet} <= 3'(i);
            step(1);
            check({dSwA, dSwD, fSwA, fSwD}, {2{i == 3, i != 3}});
        end
        swapReq <= 1'h0;
        // Pin order: source default, bus, battery dead, partner, bit stream
        for (int i = 0; i < 5; i++)
        begin
            @(posedge core_clk);
            {srcDefault, vbusPresent, batteryDead, peerDbCapable, bitStreamSeen} <= dbIn[i];
            step(5);
            check({roleSink, roleSource, driveSafeDb, driveSafe5v, commFromBus}, dbOut[i]);
        end
        for (int i = 0; i < 6; i++)
        begin
            @(posedge core_clk);
            attached <= ~attached;
            srcCaps <= srcCaps ^ 10'($urandom_range(1, 1023));
            supplyReady <= i[0];
            offerValid <= 1'h1;
            pick = 10'($urandom);
            offerCurrent <= pick;
            needCurrent <= i == 0 ? pick : 10'($urandom);
            step(1);
            check({attachChange, capsChange, transDone, reqValid, morePower, reqCurrent},
                {3'h6 | 3'(i[0]), 1'h1, needCurrent > offerCurrent,
                 needCurrent < offerCurrent ? needCurrent : offerCurrent});
        end
        offerValid <= 1'h0;
        // Second reset in mid-run clears the state and tags
        reset_n <= 1'h0;
        step(2);
        check({sendBusy, roleSink, roleSource, driveSafeDb, driveSafe5v, reqValid}, 6'h00);
        reset_n <= 1'h1;
        send(2'h1, 10'h0C3, 1'h0);
        close_out();
    end
endmodule
